//--- core/hem_defs.vh
// register offsets, field positions and reset values of the host error monitor config block
`ifndef HEM_DEFS_VH
`define HEM_DEFS_VH
`define HEM_OFS_RUN_CONTROL 8'h8F
`define HEM_OFS_FIRST_DELAY 8'h90
`define HEM_OFS_SECOND_DELAY 8'h91
`define HEM_OFS_MODE_CONFIG 8'h92
`define HEM_OFS_HIGH_PULSE_MAX 8'h93
`define HEM_OFS_ERROR_COUNTER 8'h97
`define HEM_RESET_VALUE 8'h00
`define HEM_BIT_START 0
`define HEM_BIT_MODE 7
`define HEM_BIT_ENABLE 6
`define HEM_BIT_DRV_CLEAR 5
`define HEM_THRESH_MSB 3
`define HEM_CNT_W 5
`define HEM_CNT_MAX 5'h1F
`endif

//--- core/hem_cfg_reg.v
// one 8-bit configuration register, write-locked while the monitor runs
`timescale 1ns/10ps
`include "hem_defs.vh"
module hem_cfg_reg #(
  parameter [7:0] ADDR = 8'h00,
  parameter [7:0] WMASK = 8'hFF
) (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire locked,
  output reg [7:0] value
);
  // store only when addressed and not locked; locked writes are dropped
  always @(posedge clk) begin
    if (rst) begin
      value <= `HEM_RESET_VALUE;
    end else if (wr_en && (wr_addr == ADDR) && !locked) begin // see R3 see R13
      value <= wr_data & WMASK;
    end
  end
endmodule // hem_cfg_reg

//--- core/hem_monitor_cfg.v
// configuration, write lock, error counter and driver-enable gating of the host error monitor
`timescale 1ns/10ps
`include "hem_defs.vh"
// Behaviour
// R1 - start bit runs or stops the monitor
// R2 - stopped and enabled clears driver enable
// R3 - config fields writable only while stopped
// R4 - 8-bit first delay interval field
// R5 - 8-bit second delay interval field
// R6 - bit 7 selects level or PWM
// R7 - disabled: driver enable allowed if flags clear
// R8 - enabled: start, fail/clear option, reset flag gate
// R9 - bit 5 clears driver enable on failure
// R10 - error handling when counter exceeds threshold
// R11 - counter read-only, cleared when stopped or reset
// R12 - 8-bit high-pulse maximum, locked while running
// R13 - locked writes ignored, old values kept
// R14 - host programs fields before starting
module hem_monitor_cfg (
  input wire clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire error_event,
  input wire host_reset_event,
  input wire monitor_failure_flag,
  input wire monitor_reset_flag,
  input wire other_flags_pending,
  input wire driver_set_req,
  input wire driver_clr_req,
  output reg driver_enable_bit,
  output reg error_handling_start,
  output wire monitor_start_bit,
  output wire monitor_mode_select,
  output wire [7:0] monitor_first_delay_value,
  output wire [7:0] monitor_second_delay_value,
  output wire [7:0] monitor_high_pulse_max
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] run_control;
  wire [7:0] mode_config;
  reg [`HEM_CNT_W-1:0] monitor_error_counter;
  wire monitor_enable_cfg;
  wire monitor_driver_clear_cfg;
  wire [3:0] monitor_error_threshold;
  wire driver_set_ok;
  wire driver_force_clr;
  wire counter_clear;
  wire counter_full;
  wire over_threshold;
  reg [`HEM_CNT_W-1:0] next_error_counter;
  reg next_driver_enable;
  reg next_error_handling;
  reg [7:0] next_reg_rdata;

  // start register is always writable; bits 7:1 are kept as written
  // so a read returns exactly the last byte stored
  always @(posedge clk) begin
    if (rst) begin
      run_control <= `HEM_RESET_VALUE;
    end else if (reg_wr && reg_addr == `HEM_OFS_RUN_CONTROL) begin
      run_control <= reg_wdata; // see R1
    end
  end
  assign monitor_start_bit = run_control[`HEM_BIT_START]; // see R1

  // ----------------------------------------
  // locked configuration registers
  // ----------------------------------------
  // first delay interval length, writes dropped while running
  hem_cfg_reg #(.ADDR(`HEM_OFS_FIRST_DELAY), .WMASK(8'hFF)) u_first_delay ( // see R4
    .clk(clk),
    .rst(rst),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .locked(monitor_start_bit), // see R3
    .value(monitor_first_delay_value)
  );

  // second delay interval length, same lock
  hem_cfg_reg #(.ADDR(`HEM_OFS_SECOND_DELAY), .WMASK(8'hFF)) u_second_delay ( // see R5
    .clk(clk),
    .rst(rst),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .locked(monitor_start_bit), // see R3
    .value(monitor_second_delay_value)
  );

  // mode, enable, driver clear and threshold share one byte
  hem_cfg_reg #(.ADDR(`HEM_OFS_MODE_CONFIG), .WMASK(8'hFF)) u_mode_config ( // see R6
    .clk(clk),
    .rst(rst),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .locked(monitor_start_bit), // see R3
    .value(mode_config)
  );

  // high-pulse maximum, same lock
  hem_cfg_reg #(.ADDR(`HEM_OFS_HIGH_PULSE_MAX), .WMASK(8'hFF)) u_high_max ( // see R12
    .clk(clk),
    .rst(rst),
    .wr_en(reg_wr),
    .wr_addr(reg_addr),
    .wr_data(reg_wdata),
    .locked(monitor_start_bit), // see R3
    .value(monitor_high_pulse_max)
  );

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  // bit 7 mode, bit 6 enable, bit 5 driver clear, bits 3:0 threshold
  assign monitor_mode_select = mode_config[`HEM_BIT_MODE]; // see R6
  assign monitor_enable_cfg = mode_config[`HEM_BIT_ENABLE];
  assign monitor_driver_clear_cfg = mode_config[`HEM_BIT_DRV_CLEAR]; // see R9
  assign monitor_error_threshold = mode_config[`HEM_THRESH_MSB:0];

  // ----------------------------------------
  // error counter and threshold
  // ----------------------------------------
  // clear conditions win over a coincident error event
  assign counter_clear = !monitor_start_bit || host_reset_event; // see R11
  assign counter_full = (monitor_error_counter == `HEM_CNT_MAX);

  // next counter value: clear, count or hold, saturating at the top
  always @* begin
    next_error_counter = monitor_error_counter;
    if (counter_clear) begin
      next_error_counter = {`HEM_CNT_W{1'b0}}; // see R11
    end else if (error_event && !counter_full) begin
      next_error_counter = monitor_error_counter + 5'h01;
    end
  end

  // counter register, read-only from the bus
  always @(posedge clk) begin
    if (rst) begin
      monitor_error_counter <= {`HEM_CNT_W{1'b0}};
    end else begin
      monitor_error_counter <= next_error_counter;
    end
  end

  // unsigned compare of the 5-bit count against the zero-extended threshold
  assign over_threshold = (monitor_error_counter > {1'b0, monitor_error_threshold}); // see R10

  // handling request is a level, only while the monitor runs
  always @* begin
    next_error_handling = 1'b0;
    if (monitor_start_bit && over_threshold) begin
      next_error_handling = 1'b1; // see R10
    end
  end

  // registered so the request never glitches on a counter change
  always @(posedge clk) begin
    if (rst) begin
      error_handling_start <= 1'b0;
    end else begin
      error_handling_start <= next_error_handling;
    end
  end

  // ----------------------------------------
  // driver enable gating
  // ----------------------------------------
  // a set request is honoured only under the rule for the current enable setting
  assign driver_set_ok = monitor_enable_cfg ?
    (monitor_start_bit && (!monitor_failure_flag || !monitor_driver_clear_cfg) &&
     !monitor_reset_flag && !other_flags_pending) : // see R8
    !other_flags_pending; // see R7
  // forced clear while stopped with the monitor enabled, or on failure with driver clear (bit 5) set
  assign driver_force_clr = (monitor_enable_cfg && !monitor_start_bit) || // see R2
    (monitor_driver_clear_cfg && monitor_failure_flag); // see R9

  // clears outrank a set request arriving in the same cycle
  always @* begin
    next_driver_enable = driver_enable_bit;
    if (driver_force_clr || driver_clr_req) begin
      next_driver_enable = 1'b0; // see R2 see R9
    end else if (driver_set_req && driver_set_ok) begin
      next_driver_enable = 1'b1; // see R7 see R8
    end
  end

  // driver enable register
  always @(posedge clk) begin
    if (rst) begin
      driver_enable_bit <= 1'b0;
    end else begin
      driver_enable_bit <= next_driver_enable;
    end
  end

  // ----------------------------------------
  // read back, registered one cycle
  // ----------------------------------------
  // read mux; unmapped offsets read as zero
  always @* begin
    case (reg_addr)
      `HEM_OFS_RUN_CONTROL: next_reg_rdata = run_control;
      `HEM_OFS_FIRST_DELAY: next_reg_rdata = monitor_first_delay_value;
      `HEM_OFS_SECOND_DELAY: next_reg_rdata = monitor_second_delay_value;
      `HEM_OFS_MODE_CONFIG: next_reg_rdata = mode_config;
      `HEM_OFS_HIGH_PULSE_MAX: next_reg_rdata = monitor_high_pulse_max;
      `HEM_OFS_ERROR_COUNTER: next_reg_rdata = {3'h0, monitor_error_counter}; // see R11
      default: next_reg_rdata = 8'h00;
    endcase
  end

  // capture on a read strobe and hold until the next read
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule // hem_monitor_cfg

//--- verif/hem_host_model.sv
// host model that sends bursts of monitor error pulses
`timescale 1ns/10ps
module hem_host_model (
  input wire clk,
  input wire [4:0] n_err,
  input wire go,
  output reg error_event
);
  reg [4:0] left = 5'h00;
  initial error_event = 1'b0;
  // one error pulse per cycle until the burst is spent
  always @(posedge clk) begin
    if (go) left <= n_err;
    else if (left != 5'h00) left <= left - 5'h01;
    error_event <= !go && left != 5'h00;
  end
endmodule // hem_host_model

//--- verif/hem_monitor_cfg_assertions.sv
// assertions on the host error monitor config block
`timescale 1ns/10ps
module hem_monitor_cfg_assertions (
  input wire clk, rst, reg_wr, other_flags_pending, driver_clr_req, driver_enable_bit,
  input wire error_handling_start, monitor_start_bit, monitor_mode_select,
  input wire [7:0] reg_addr, reg_wdata, monitor_first_delay_value, monitor_second_delay_value,
  input wire [7:0] monitor_high_pulse_max
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire unl = reg_wr && !monitor_start_bit;
  sequence s_stopped; !monitor_start_bit ##1 !monitor_start_bit; endsequence
  AST_START: assert property (reg_wr && reg_addr == 8'h8F |=> monitor_start_bit == $past(reg_wdata[0]))
    else $error("start bit");
  AST_LOCK: assert property (monitor_start_bit && reg_wr |=> $stable(monitor_first_delay_value))
    else $error("locked write");
  AST_DLY1: assert property (unl && reg_addr == 8'h90 |=> monitor_first_delay_value == $past(reg_wdata))
    else $error("delay one");
  AST_DLY2: assert property (unl && reg_addr == 8'h91 |=> monitor_second_delay_value == $past(reg_wdata))
    else $error("delay two");
  AST_MODE: assert property (unl && reg_addr == 8'h92 |=> monitor_mode_select == $past(reg_wdata[7]))
    else $error("mode bit");
  AST_HMAX: assert property (unl && reg_addr == 8'h93 |=> monitor_high_pulse_max == $past(reg_wdata))
    else $error("high max");
  AST_EHS: assert property (s_stopped |-> !error_handling_start)
    else $error("handling while stopped");
  AST_FLAGS: assert property (other_flags_pending && !driver_enable_bit |=> !driver_enable_bit)
    else $error("driver set with flags");
  AST_CLR: assert property (driver_clr_req |=> !driver_enable_bit)
    else $error("driver clear");
endmodule // hem_monitor_cfg_assertions
bind hem_monitor_cfg hem_monitor_cfg_assertions chk (.*);

//--- verif/tb_hem_monitor_cfg.sv
// self-checking bench for the host error monitor config block
`timescale 1ns/10ps
module tb_hem_monitor_cfg;
  logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, fail = 0, oth = 0, set = 0, clr = 0, hr = 0, rfl = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v, d1, d2, hm;
  logic [4:0] n_err = 5'h00;
  logic ev, drv, ehs, sb, msel;
  int error_cnt = 0, compares = 0, cyc = 0;
  hem_host_model host (.clk(clk), .n_err(n_err), .go(go), .error_event(ev));
  hem_monitor_cfg uut (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdata), .error_event(ev), .host_reset_event(hr), .monitor_failure_flag(fail),
    .monitor_reset_flag(rfl), .other_flags_pending(oth), .driver_set_req(set), .driver_clr_req(clr),
    .driver_enable_bit(drv), .error_handling_start(ehs), .monitor_start_bit(sb), .monitor_mode_select(msel),
    .monitor_first_delay_value(d1), .monitor_second_delay_value(d2), .monitor_high_pulse_max(hm));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin error_cnt++; print_verdict; end
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin error_cnt++; $display("Error %0t got %h exp %h", $time, got, exp); end
  endtask
  task w(input logic [7:0] a, d);
    @(negedge clk); wr = 1; addr = a; wd = d;
    @(negedge clk); wr = 0;
  endtask
  task r(input logic [7:0] a);
    @(negedge clk); rd = 1; addr = a;
    @(negedge clk); rd = 0;
    @(negedge clk); v = rdata;
  endtask
  task automatic p(ref logic s);
    @(negedge clk); s = 1;
    @(negedge clk); s = 0;
    @(negedge clk);
  endtask
  task t_regs;
    for (int i = 0; i < 5; i++) begin r(8'h8F + 8'(i)); chk(v, 8'h00); end
    for (int i = 1; i < 5; i++) w(8'h8F + 8'(i), 8'h10 * 8'(i) + 8'h03);
    for (int i = 1; i < 5; i++) begin r(8'h8F + 8'(i)); chk(v, 8'h10 * 8'(i) + 8'h03); end
    w(8'h97, 8'hFF); r(8'h97); chk(v, 8'h00);
    r(8'hA0); chk(v, 8'h00);
  endtask
  task t_lock;
    w(8'h8F, 8'h01); w(8'h90, 8'h55); w(8'h91, 8'h66); w(8'h92, 8'hFF); w(8'h93, 8'h77);
    chk({7'h0, sb}, 8'h01);
    chk({7'h0, msel}, 8'h00);
    r(8'h90); chk(v, 8'h13);
    r(8'h92); chk(v, 8'h33);
    chk(d1, 8'h13); chk(d2, 8'h23);
    chk(hm, 8'h43);
    w(8'h8F, 8'h00);
  endtask
  task t_drv;
    oth = 1; p(set); chk({7'h0, drv}, 8'h00);
    oth = 0; p(set); chk({7'h0, drv}, 8'h01);
    p(clr); chk({7'h0, drv}, 8'h00);
    w(8'h92, 8'h60); p(set); chk({7'h0, drv}, 8'h00);
    w(8'h8F, 8'h01); rfl = 1; p(set); chk({7'h0, drv}, 8'h00);
    rfl = 0; p(set); chk({7'h0, drv}, 8'h01);
    fail = 1; repeat (2) @(negedge clk); chk({7'h0, drv}, 8'h00);
    fail = 0; w(8'h8F, 8'h00);
    w(8'h92, 8'h40); w(8'h8F, 8'h01); fail = 1; p(set); chk({7'h0, drv}, 8'h01);
    repeat (2) @(negedge clk); chk({7'h0, drv}, 8'h01);
    fail = 0; w(8'h8F, 8'h00); @(negedge clk); chk({7'h0, drv}, 8'h00);
  endtask
  task t_cnt;
    w(8'h92, 8'h82); chk({7'h0, msel}, 8'h01);
    w(8'h8F, 8'h01);
    n_err = 5'h02; p(go); repeat (4) @(negedge clk); chk({7'h0, ehs}, 8'h00);
    n_err = 5'h01; p(go); repeat (3) @(negedge clk); chk({7'h0, ehs}, 8'h01);
    r(8'h97); chk(v, 8'h03);
    w(8'h8F, 8'h00); r(8'h97); chk(v, 8'h00);
    w(8'h8F, 8'h01); p(go); r(8'h97); chk(v, 8'h01);
    p(hr); r(8'h97); chk(v, 8'h00);
    w(8'h8F, 8'h00);
  endtask
  initial begin
    repeat (2) @(negedge clk); rst = 0;
    t_regs; t_lock; t_drv; t_cnt;
    print_verdict;
  end
  task print_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule // tb_hem_monitor_cfg
